// [verilog/rtcv_value_regs.sv]
// Time and alarm value registers on an APB slave
//
// Implementation choices: the placing of the registers and the APB slave port.
`include "rtcv_map.svh"
`default_nettype none
module rtcv_value_regs
  import rtcv_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [15:0] minutes_seconds_time,
  output logic      [15:0] alarm_month_day,
  output logic      [15:0] alarm_weekday_hour,
  output logic             clock_write_enable
);

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  rtcv_apb_req_t req;
  logic          acc_wr;
  logic          acc_rd;
  logic          wr_ms;
  logic          wr_md;
  logic          wr_wh;
  logic          wr_ctl;
  logic          hit;
  logic          clock_write_enable_r;
  logic [31:0]   prdata_r;
  logic [31:0]   prdata_nxt;
  logic          pslverr_r;
  rtcv_min_sec_t ms_view;

  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [11:0] off);
    addr_is = (a == off);
  endfunction

  assign req.sel   = psel;
  assign req.en    = penable;
  assign req.write = pwrite;
  assign req.addr  = paddr;
  assign req.wdata = pwdata;

  rtcv_apb_decode u_dec (
    .pclk    (pclk),
    .presetn (presetn),
    .req     (req),
    .acc_wr  (acc_wr),
    .acc_rd  (acc_rd),
    .pready  (pready)
  );

  assign hit = addr_is(paddr, `RTCV_OFF_MIN_SEC)
             | addr_is(paddr, `RTCV_OFF_ALM_MTH_DY)
             | addr_is(paddr, `RTCV_OFF_ALM_WD_HR)
             | addr_is(paddr, `RTCV_OFF_CTRL);

  assign wr_ms  = acc_wr && addr_is(paddr, `RTCV_OFF_MIN_SEC);
  // Gate is sampled in the same cycle as the write itself
  assign wr_md  = acc_wr && addr_is(paddr, `RTCV_OFF_ALM_MTH_DY)
                  && clock_write_enable_r;
  assign wr_wh  = acc_wr && addr_is(paddr, `RTCV_OFF_ALM_WD_HR);
  assign wr_ctl = acc_wr && addr_is(paddr, `RTCV_OFF_CTRL);

  // --------------------------------------------------------------------
  // Value registers
  // --------------------------------------------------------------------
  rtcv_field_reg #(.MASK(`RTCV_MASK_MIN_SEC)) u_ms (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_ms),
    .wr_data (pwdata[15:0]),
    .value   (minutes_seconds_time)
  );

  rtcv_field_reg #(.MASK(`RTCV_MASK_MTH_DY)) u_md (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_md),
    .wr_data (pwdata[15:0]),
    .value   (alarm_month_day)
  );

  rtcv_field_reg #(.MASK(`RTCV_MASK_WD_HR)) u_wh (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_wh),
    .wr_data (pwdata[15:0]),
    .value   (alarm_weekday_hour)
  );

  assign ms_view = rtcv_min_sec_t'(minutes_seconds_time);

  // --------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_write_enable_r <= `RTCV_CTRL_RESET;
    end else if (wr_ctl) begin
      clock_write_enable_r <= pwdata[`RTCV_CTRL_WREN_BIT];
    end
  end

  assign clock_write_enable = clock_write_enable_r;

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    unique case (1'b1)
      addr_is(paddr, `RTCV_OFF_MIN_SEC):
        prdata_nxt = {16'h0000, minutes_seconds_time};
      addr_is(paddr, `RTCV_OFF_ALM_MTH_DY):
        prdata_nxt = {16'h0000, alarm_month_day};
      addr_is(paddr, `RTCV_OFF_ALM_WD_HR):
        prdata_nxt = {16'h0000, alarm_weekday_hour};
      addr_is(paddr, `RTCV_OFF_CTRL):
        prdata_nxt = {31'h0000_0000, clock_write_enable_r};
      default:
        prdata_nxt = 32'h0000_0000;
    endcase
  end

  // Registered at setup so data is a flop output during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_r <= prdata_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_r <= !hit;
    end
  end

  assign prdata  = prdata_r;
  assign pslverr = pslverr_r && psel && penable;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  a_ms_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (minutes_seconds_time[15] == 1'b0) && (minutes_seconds_time[7] == 1'b0))
    else $error("unused minutes/seconds bits set");

  a_md_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (alarm_month_day & ~`RTCV_MASK_MTH_DY) == 16'h0000)
    else $error("unused month/day bits set");

  a_wh_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (alarm_weekday_hour & ~`RTCV_MASK_WD_HR) == 16'h0000)
    else $error("unused weekday/hour bits set");

  a_md_gated_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (acc_wr && addr_is(paddr, `RTCV_OFF_ALM_MTH_DY) && !clock_write_enable)
    |=> $stable(alarm_month_day))
    else $error("month/day changed without write enable");

  a_md_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    (acc_wr && addr_is(paddr, `RTCV_OFF_ALM_MTH_DY) && clock_write_enable)
    |=> alarm_month_day[12] == $past(pwdata[12])
        && alarm_month_day[11:8] == $past(pwdata[11:8])
        && alarm_month_day[5:0] == $past(pwdata[5:0]))
    else $error("month/day write lost");

  a_ms_fields: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ms |=> ms_view.min_tens == $past(pwdata[14:12])
           && ms_view.min_ones == $past(pwdata[11:8])
           && ms_view.sec_tens == $past(pwdata[6:4])
           && ms_view.sec_ones == $past(pwdata[3:0]))
    else $error("minutes/seconds field misplaced");

  a_wh_fields: assert property (@(posedge pclk) disable iff (!presetn)
    wr_wh |=> alarm_weekday_hour[10:8] == $past(pwdata[10:8])
           && alarm_weekday_hour[5:4] == $past(pwdata[5:4])
           && alarm_weekday_hour[3:0] == $past(pwdata[3:0]))
    else $error("weekday/hour field misplaced");

  a_ms_hold_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_ms |=> $stable(minutes_seconds_time))
    else $error("minutes/seconds changed without write");

  a_rd_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite) |-> prdata[31:16] == 16'h0000)
    else $error("read upper half not zero");

endmodule
`default_nettype wire

// [verilog/rtcv_map.svh]
// Register offsets, field positions and reset values for the value registers
`ifndef RTCV_MAP_SVH
`define RTCV_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define RTCV_OFF_MIN_SEC    12'h000
`define RTCV_OFF_ALM_MTH_DY 12'h004
`define RTCV_OFF_ALM_WD_HR  12'h008
`define RTCV_OFF_CTRL       12'h00C

// ----------------------------------------------------------------------
// Writable bit masks (unused positions read zero)
// ----------------------------------------------------------------------
`define RTCV_MASK_MIN_SEC   16'h7F7F
`define RTCV_MASK_MTH_DY    16'h1F3F
`define RTCV_MASK_WD_HR     16'h073F

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define RTCV_CTRL_WREN_BIT  0
`define RTCV_RESET_VALUE    16'h0000
`define RTCV_CTRL_RESET     1'b0

`endif

// [verilog/rtcv_pkg.sv]
// Types shared by the value-register block
`default_nettype none
package rtcv_pkg;

  typedef struct packed {
    logic        sel;
    logic        en;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } rtcv_apb_req_t;

  typedef struct packed {
    logic        zero15;
    logic [2:0]  min_tens;
    logic [3:0]  min_ones;
    logic        zero7;
    logic [2:0]  sec_tens;
    logic [3:0]  sec_ones;
  } rtcv_min_sec_t;

  typedef enum {RTCV_IDLE, RTCV_ACCESS} rtcv_state_t;

endpackage
`default_nettype wire

// [verilog/rtcv_field_reg.sv]
// One 16-bit value register with write mask and write enable
`default_nettype none
module rtcv_field_reg
  import rtcv_pkg::*;
#(
  parameter logic [15:0] MASK = 16'hFFFF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] value
);

  logic [15:0] value_r;

  // Unused bits never store, so they always read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_r <= 16'h0000;
    end else if (wr_en) begin
      value_r <= wr_data & MASK;
    end
  end

  assign value = value_r;

endmodule
`default_nettype wire

// [verilog/rtcv_apb_decode.sv]
// APB setup/access tracker producing a one-cycle access strobe
`default_nettype none
module rtcv_apb_decode
  import rtcv_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire rtcv_apb_req_t req,
  output logic               acc_wr,
  output logic               acc_rd,
  output logic               pready
);

  rtcv_state_t state_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= RTCV_IDLE;
    end else begin
      unique case (state_r)
        RTCV_IDLE: begin
          if (req.sel && !req.en) begin
            state_r <= RTCV_ACCESS;
          end
        end
        RTCV_ACCESS: begin
          state_r <= RTCV_IDLE;
        end
      endcase
    end
  end

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign acc_wr = req.sel && req.en && req.write;
  assign acc_rd = req.sel && req.en && !req.write;

endmodule
`default_nettype wire

// [tb/rtcv_value_regs_bench.sv]
// Self-checking bench for the time and alarm value registers
`include "rtcv_map.svh"
`default_nettype none
module rtcv_value_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;

  // Outside every decoded slot
  localparam logic [11:0] NO_REG = 12'h010;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] ms_val;
  logic [15:0] md_val;
  logic [15:0] wh_val;
  logic        wren;
  logic [31:0] rd_data;
  logic        rd_err;
  int          bad_count;
  int          total_checks;

  rtcv_value_regs i_rtcv_value_regs (
    .pclk                 (pclk),
    .presetn              (presetn),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .minutes_seconds_time (ms_val),
    .alarm_month_day      (md_val),
    .alarm_weekday_hour   (wh_val),
    .clock_write_enable   (wren)
  );

  always #12.5 pclk = ~pclk;

  // ----------------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------------
  task automatic test_done();
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("ERROR pready expected 1 seen %b", pready);
      test_done();
    end
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp,
                       input string nm);
    xfer(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd_data);
    chk("pslverr", 32'h0, {31'h0, rd_err});
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_min_sec();
    xfer(1'b1, `RTCV_OFF_MIN_SEC, 32'hFFFF_FFFF);
    rdchk(`RTCV_OFF_MIN_SEC, 32'h0000_7F7F, "min_sec ones");
    xfer(1'b1, `RTCV_OFF_MIN_SEC, 32'hA5A5_3052);
    rdchk(`RTCV_OFF_MIN_SEC, 32'h0000_3052, "min_sec read");
    chk("min tens", 32'h3, {29'h0, ms_val[14:12]});
    chk("min ones", 32'h0, {28'h0, ms_val[11:8]});
    chk("sec tens", 32'h5, {29'h0, ms_val[6:4]});
    chk("sec ones", 32'h2, {28'h0, ms_val[3:0]});
  endtask

  task automatic t_month_day();
    xfer(1'b1, `RTCV_OFF_ALM_MTH_DY, 32'h0000_1231);
    rdchk(`RTCV_OFF_ALM_MTH_DY, 32'h0, "md locked");
    xfer(1'b1, `RTCV_OFF_CTRL, 32'h0000_0001);
    // Register outputs settle after the accepting edge
    @(negedge pclk);
    chk("wren", 32'h1, {31'h0, wren});
    xfer(1'b1, `RTCV_OFF_ALM_MTH_DY, 32'hFFFF_FFFF);
    rdchk(`RTCV_OFF_ALM_MTH_DY, 32'h0000_1F3F, "md ones");
    xfer(1'b1, `RTCV_OFF_ALM_MTH_DY, 32'h0000_1231);
    @(negedge pclk);
    chk("month tens", 32'h1, {31'h0, md_val[12]});
    chk("month ones", 32'h2, {28'h0, md_val[11:8]});
    chk("day tens", 32'h3, {30'h0, md_val[5:4]});
    chk("day ones", 32'h1, {28'h0, md_val[3:0]});
    xfer(1'b1, `RTCV_OFF_CTRL, 32'h0000_0000);
    xfer(1'b1, `RTCV_OFF_ALM_MTH_DY, 32'h0000_0000);
    rdchk(`RTCV_OFF_ALM_MTH_DY, 32'h0000_1231, "md held");
  endtask

  task automatic t_weekday_hour();
    xfer(1'b1, `RTCV_OFF_ALM_WD_HR, 32'hFFFF_FFFF);
    rdchk(`RTCV_OFF_ALM_WD_HR, 32'h0000_073F, "wh ones");
    xfer(1'b1, `RTCV_OFF_ALM_WD_HR, 32'h0000_0623);
    @(negedge pclk);
    chk("weekday", 32'h6, {29'h0, wh_val[10:8]});
    chk("hour tens", 32'h2, {30'h0, wh_val[5:4]});
    chk("hour ones", 32'h3, {28'h0, wh_val[3:0]});
  endtask

  task automatic t_unmapped();
    xfer(1'b1, NO_REG, 32'hFFFF_FFFF);
    chk("pslverr wr", 32'h1, {31'h0, rd_err});
    xfer(1'b0, NO_REG, 32'h0000_0000);
    chk("pslverr rd", 32'h1, {31'h0, rd_err});
    chk("unmapped rd", 32'h0, rd_data);
    rdchk(`RTCV_OFF_MIN_SEC, 32'h0000_3052, "min_sec kept");
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    pclk         = 1'b0;
    presetn      = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 12'h000;
    pwdata       = 32'h0000_0000;
    bad_count    = 0;
    total_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`RTCV_OFF_MIN_SEC, 32'h0, "min_sec reset");
    rdchk(`RTCV_OFF_CTRL, 32'h0, "ctrl reset");
    t_min_sec();
    t_month_day();
    t_weekday_hour();
    t_unmapped();
    test_done();
  end
endmodule
`default_nettype wire
